//--- hdl/pfd_top.sv
// Phase detector and pump control with APB register access
// Assumes divided reference and divided oscillator arrive on async pins
//
// Functional notes
// - Compare divided edges, drive raise/lower requests
// - Swap bit exchanges the two compared inputs
// - Force bit holds raise request on
// - Force bit holds lower request on
// - Large error: state machine holds pump direction
// - Hold polarity until frequency difference near zero
// - Slip prevention needs enable and output enable
// - Delay field sets slip sensitivity
// - Two saturation flags show which input leads
// - Raise and lower gain codes set independently
// - Gain code: up to 127 steps of 20uA
// - Offset magnitude from seven-bit field
// - Offset steered to raise or lower pump
//
// The implementer's own choices: the APB register port and the address map.
`include "pfd_map.svh"
`timescale 1ns/100ps
`default_nettype none

module pfd_top
   import pfd_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Divided inputs
   input wire logic refDivIn,
   input wire logic vcoDivIn,
   // Pump stage control
   output logic raiseRequest,
   output logic lowerRequest,
   output pfd_code_t raiseGain,
   output pfd_code_t lowerGain,
   output pfd_code_t offsetMag,
   output logic offsetToRaise,
   output logic offsetToLower,
   // Companion divider
   output logic raiseSaturationFlag,
   output logic lowerSaturationFlag
);

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   function automatic logic regHit(input logic [7:0] addr,
                                   input logic [5:0] idx);
      return addr == {idx, 2'b00};
   endfunction

   function automatic logic regMapped(input logic [7:0] addr);
      return regHit(addr, `PFD_IDX_CFG) ||
             regHit(addr, `PFD_IDX_DETCTL) ||
             regHit(addr, `PFD_IDX_PUMP) ||
             regHit(addr, `PFD_IDX_STAT);
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0] refSync;
      logic [2:0] vcoSync;
      logic [31:0] cfgReg;
      logic [31:0] detCtrlReg;
      logic [31:0] pumpReg;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic raiseRequest;
      logic lowerRequest;
      logic raiseSat;
      logic lowerSat;
   } pfd_top_s;

   pfd_top_s q;
   pfd_top_s d;

   pfd_if link ();

   logic access;
   logic wrDone;
   logic slipEn;
   logic [31:0] statusReg;

   // ---------------------------------------------------------------
   // Submodules
   // ---------------------------------------------------------------
   pfd_detector u_detector (
      .sys_clk (sys_clk),
      .rst_n (rst_n),
      .det (link.det)
   );

   pfd_slip u_slip (
      .sys_clk (sys_clk),
      .rst_n (rst_n),
      .sl (link.slip)
   );

   // ---------------------------------------------------------------
   // Edges and control to the comparator and slip controller
   // ---------------------------------------------------------------
   // Sync stage 1 feeds only stage 2; edges come from stages 2 and 3
   assign link.refEdge = q.refSync[1] & ~q.refSync[2];
   assign link.vcoEdge = q.vcoSync[1] & ~q.vcoSync[2];
   assign link.swap = q.detCtrlReg[`PFD_SWAP_BIT];
   assign link.delay =
      q.detCtrlReg[`PFD_DELAY_MSB:`PFD_DELAY_LSB];
   assign slipEn = q.cfgReg[`PFD_SLIP_EN_BIT] &
                   q.cfgReg[`PFD_SLIP_OE_BIT];
   assign link.slipEn = slipEn;

   // ---------------------------------------------------------------
   // Bus phases
   // ---------------------------------------------------------------
   // One wait state: pready follows the first access cycle
   assign access = psel && penable && !q.pready;
   assign wrDone = psel && penable && q.pready && pwrite;

   always_comb begin
      statusReg = 32'h0000_0000;
      statusReg[`PFD_ST_RAISE_BIT] = q.raiseRequest;
      statusReg[`PFD_ST_LOWER_BIT] = q.lowerRequest;
      statusReg[`PFD_ST_RSAT_BIT] = link.raiseSat;
      statusReg[`PFD_ST_LSAT_BIT] = link.lowerSat;
      statusReg[`PFD_ST_SLIPR_BIT] = link.slipRaise;
      statusReg[`PFD_ST_SLIPL_BIT] = link.slipLower;
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      d.refSync = {q.refSync[1:0], refDivIn};
      d.vcoSync = {q.vcoSync[1:0], vcoDivIn};
      d.pready = 1'b0;
      d.pslverr = 1'b0;

      if (access) begin
         d.pready = 1'b1;
         d.pslverr = !regMapped(paddr);
         if (!pwrite) begin
            if (regHit(paddr, `PFD_IDX_CFG)) begin
               d.prdata = q.cfgReg;
            end else if (regHit(paddr, `PFD_IDX_DETCTL)) begin
               d.prdata = q.detCtrlReg;
            end else if (regHit(paddr, `PFD_IDX_PUMP)) begin
               d.prdata = q.pumpReg;
            end else if (regHit(paddr, `PFD_IDX_STAT)) begin
               d.prdata = statusReg;
            end else begin
               d.prdata = 32'h0000_0000;
            end
         end
      end

      // No shadow copy: a field drives the logic from the next edge on
      if (wrDone) begin
         if (regHit(paddr, `PFD_IDX_CFG)) begin
            d.cfgReg = pwdata & `PFD_MASK_CFG;
         end
         if (regHit(paddr, `PFD_IDX_DETCTL)) begin
            d.detCtrlReg = pwdata & `PFD_MASK_DETCTL;
         end
         if (regHit(paddr, `PFD_IDX_PUMP)) begin
            d.pumpReg = pwdata & `PFD_MASK_PUMP;
         end
      end

      // Forcing wins over everything, then the slip hold direction
      d.raiseRequest = q.pumpReg[`PFD_FORCE_RAISE_BIT] |
                       link.slipRaise |
                       (link.detRaise & !link.slipLower);
      d.lowerRequest = q.pumpReg[`PFD_FORCE_LOWER_BIT] |
                       link.slipLower |
                       (link.detLower & !link.slipRaise);

      // The companion only sees saturation while the feature is on
      d.raiseSat = slipEn & link.raiseSat;
      d.lowerSat = slipEn & link.lowerSat;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{
            refSync: 3'h0,
            vcoSync: 3'h0,
            cfgReg: `PFD_RST_CFG,
            detCtrlReg: `PFD_RST_DETCTL,
            pumpReg: `PFD_RST_PUMP,
            prdata: 32'h0000_0000,
            pready: 1'b0,
            pslverr: 1'b0,
            raiseRequest: 1'b0,
            lowerRequest: 1'b0,
            raiseSat: 1'b0,
            lowerSat: 1'b0
         };
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign raiseRequest = q.raiseRequest;
   assign lowerRequest = q.lowerRequest;
   // Each code step is one unit of pump current, full scale 127 steps
   assign raiseGain = q.pumpReg[`PFD_RGAIN_MSB:`PFD_RGAIN_LSB];
   assign lowerGain = q.pumpReg[`PFD_LGAIN_MSB:`PFD_LGAIN_LSB];
   assign offsetMag = q.pumpReg[`PFD_OFS_MSB:`PFD_OFS_LSB];
   assign offsetToRaise = q.pumpReg[`PFD_OFS_RAISE_BIT];
   assign offsetToLower = q.pumpReg[`PFD_OFS_LOWER_BIT];
   // Read by the companion divider, which retunes the oscillator side on raise saturation
   assign raiseSaturationFlag = q.raiseSat;
   assign lowerSaturationFlag = q.lowerSat;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_force_raise;
      @(posedge sys_clk) disable iff (!rst_n)
      q.pumpReg[`PFD_FORCE_RAISE_BIT] |=> raiseRequest;
   endproperty
   a_force_raise: assert property (p_force_raise)
      else $error("forced raise not active");

   property p_force_lower;
      @(posedge sys_clk) disable iff (!rst_n)
      q.pumpReg[`PFD_FORCE_LOWER_BIT] |=> lowerRequest;
   endproperty
   a_force_lower: assert property (p_force_lower)
      else $error("forced lower not active");

   property p_slip_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      (link.slipRaise && !q.pumpReg[`PFD_FORCE_LOWER_BIT])
         |=> (raiseRequest && !lowerRequest);
   endproperty
   a_slip_hold: assert property (p_slip_hold)
      else $error("slip hold direction not kept");

   property p_sat_gate;
      @(posedge sys_clk) disable iff (!rst_n)
      !slipEn |=> (!raiseSaturationFlag && !lowerSaturationFlag);
   endproperty
   a_sat_gate: assert property (p_sat_gate)
      else $error("saturation shown while disabled");

   property p_sat_flag;
      @(posedge sys_clk) disable iff (!rst_n)
      (slipEn && link.raiseSat) |=> raiseSaturationFlag;
   endproperty
   a_sat_flag: assert property (p_sat_flag)
      else $error("raise saturation not flagged");

   property p_gain_write;
      @(posedge sys_clk) disable iff (!rst_n)
      (wrDone && regHit(paddr, `PFD_IDX_PUMP))
         |=> (raiseGain == $past(pwdata[6:0]) &&
              lowerGain == $past(pwdata[13:7]));
   endproperty
   a_gain_write: assert property (p_gain_write)
      else $error("gain codes not updated");

   property p_offset_write;
      @(posedge sys_clk) disable iff (!rst_n)
      (wrDone && regHit(paddr, `PFD_IDX_PUMP))
         |=> (offsetToRaise == $past(pwdata[21]) &&
              offsetMag == $past(pwdata[20:14]));
   endproperty
   a_offset_write: assert property (p_offset_write)
      else $error("offset fields not updated");

   property p_ready_pulse;
      @(posedge sys_clk) disable iff (!rst_n)
      access |=> pready ##1 !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready not a single cycle");

   property p_unmapped;
      @(posedge sys_clk) disable iff (!rst_n)
      (access && !regMapped(paddr)) |=> (pready && pslverr);
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not flagged");

endmodule

`default_nettype wire

//--- hdl/pfd_map.svh
// Offsets, field positions, reset values and figures of the detector block
// Assumes a 32-bit APB slave with one aligned word per register
`ifndef PFD_MAP_SVH
`define PFD_MAP_SVH

// Register indices; byte address is index times four
`define PFD_IDX_CFG 6'h01
`define PFD_IDX_DETCTL 6'h03
`define PFD_IDX_PUMP 6'h04
`define PFD_IDX_STAT 6'h06

// Configuration register fields
`define PFD_SLIP_EN_BIT 4
`define PFD_SLIP_OE_BIT 13

// Detector control register fields
`define PFD_SWAP_BIT 4
`define PFD_DELAY_MSB 2
`define PFD_DELAY_LSB 0

// Pump register fields
`define PFD_RGAIN_MSB 6
`define PFD_RGAIN_LSB 0
`define PFD_LGAIN_MSB 13
`define PFD_LGAIN_LSB 7
`define PFD_OFS_MSB 20
`define PFD_OFS_LSB 14
`define PFD_OFS_RAISE_BIT 21
`define PFD_OFS_LOWER_BIT 22
`define PFD_FORCE_RAISE_BIT 26
`define PFD_FORCE_LOWER_BIT 27

// Status register fields
`define PFD_ST_RAISE_BIT 0
`define PFD_ST_LOWER_BIT 1
`define PFD_ST_RSAT_BIT 2
`define PFD_ST_LSAT_BIT 3
`define PFD_ST_SLIPR_BIT 4
`define PFD_ST_SLIPL_BIT 5

// Writable bits and reset values
`define PFD_MASK_CFG 32'h0000_2010
`define PFD_MASK_DETCTL 32'h0000_0017
`define PFD_MASK_PUMP 32'h0c7f_ffff
`define PFD_RST_CFG 32'h0000_0000
`define PFD_RST_DETCTL 32'h0000_0000
`define PFD_RST_PUMP 32'h0000_0000

// Pump current figures and lead count limit
`define PFD_GAIN_STEP_UA 20
`define PFD_GAIN_STEPS 7'h7f
`define PFD_LEAD_MAX 4'hf

`endif

//--- hdl/pfd_pkg.sv
// Types shared by the detector block modules
// Assumes the constants come from pfd_map.svh
package pfd_pkg;

   typedef enum logic [1:0] {
      SLIP_IDLE = 2'b00,
      SLIP_RAISE = 2'b01,
      SLIP_LOWER = 2'b10
   } pfd_slip_e;

   typedef logic [6:0] pfd_code_t;
   typedef logic [3:0] pfd_lead_t;

endpackage

//--- hdl/pfd_if.sv
// Signals between the top, the edge comparator and the slip controller
// Assumes all parties run on sys_clk
`timescale 1ns/100ps
`default_nettype none

interface pfd_if;
   logic refEdge;
   logic vcoEdge;
   logic swap;
   logic [2:0] delay;
   logic detRaise;
   logic detLower;
   logic raiseSat;
   logic lowerSat;
   logic slipEn;
   logic slipRaise;
   logic slipLower;

   modport det (input refEdge, vcoEdge, swap, delay,
                output detRaise, detLower, raiseSat, lowerSat);
   modport slip (input slipEn, raiseSat, lowerSat,
                 output slipRaise, slipLower);
   modport ctl (output refEdge, vcoEdge, swap, delay, slipEn,
                input detRaise, detLower, raiseSat, lowerSat,
                input slipRaise, slipLower);
endinterface

`default_nettype wire

//--- hdl/pfd_detector.sv
// Edge comparator: raise/lower requests and lead saturation
// Assumes one-cycle edge pulses already synchronised to sys_clk
`include "pfd_map.svh"
`timescale 1ns/100ps
`default_nettype none

module pfd_detector
   import pfd_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Control side
   pfd_if.det det
);

   typedef struct packed {
      logic raiseHeld;
      logic lowerHeld;
      logic leadRef;
      pfd_lead_t cnt;
   } pfd_det_s;

   pfd_det_s q;
   pfd_det_s d;
   logic a;
   logic b;

   // ---------------------------------------------------------------
   // Comparison
   // ---------------------------------------------------------------
   always_comb begin
      a = det.swap ? det.vcoEdge : det.refEdge;
      b = det.swap ? det.refEdge : det.vcoEdge;
      d = q;
      d.raiseHeld = q.raiseHeld | a;
      d.lowerHeld = q.lowerHeld | b;
      if (d.raiseHeld && d.lowerHeld) begin
         d.raiseHeld = 1'b0;
         d.lowerHeld = 1'b0;
      end
      // A second edge on one side before the other means over 2 pi
      if (a && !b) begin
         if (q.lowerHeld) begin
            d.cnt = 4'h0;
         end else if (q.raiseHeld) begin
            if (!q.leadRef) begin
               d.leadRef = 1'b1;
               d.cnt = 4'h1;
            end else if (q.cnt != `PFD_LEAD_MAX) begin
               d.cnt = q.cnt + 4'h1;
            end
         end
      end else if (b && !a) begin
         if (q.raiseHeld) begin
            d.cnt = 4'h0;
         end else if (q.lowerHeld) begin
            if (q.leadRef) begin
               d.leadRef = 1'b0;
               d.cnt = 4'h1;
            end else if (q.cnt != `PFD_LEAD_MAX) begin
               d.cnt = q.cnt + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign det.detRaise = q.raiseHeld;
   assign det.detLower = q.lowerHeld;
   assign det.raiseSat = q.leadRef && (q.cnt > {1'b0, det.delay});
   assign det.lowerSat = !q.leadRef && (q.cnt > {1'b0, det.delay});

   property p_pair_clears;
      @(posedge sys_clk) disable iff (!rst_n)
      (a && b) |=> (!q.raiseHeld && !q.lowerHeld);
   endproperty
   a_pair_clears: assert property (p_pair_clears)
      else $error("paired edges did not clear requests");

   property p_swap_raise;
      @(posedge sys_clk) disable iff (!rst_n)
      (det.swap && det.vcoEdge && !det.refEdge && !q.lowerHeld)
         |=> q.raiseHeld;
   endproperty
   a_swap_raise: assert property (p_swap_raise)
      else $error("swapped input did not raise");

endmodule

`default_nettype wire

//--- hdl/pfd_slip.sv
// Slip prevention state machine holding the pump in one direction
// Assumes saturation indications from the edge comparator
`timescale 1ns/100ps
`default_nettype none

module pfd_slip
   import pfd_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Control side
   pfd_if.slip sl
);

   typedef struct packed {
      pfd_slip_e st;
   } pfd_sl_s;

   pfd_sl_s q;
   pfd_sl_s d;

   // ---------------------------------------------------------------
   // Direction hold
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      case (q.st)
         SLIP_IDLE: begin
            if (sl.slipEn && sl.raiseSat) begin
               d.st = SLIP_RAISE;
            end else if (sl.slipEn && sl.lowerSat) begin
               d.st = SLIP_LOWER;
            end
         end
         // Leave once the lead is gone, i.e. frequencies close, or once slipEn drops
         SLIP_RAISE: begin
            if (!sl.slipEn || !sl.raiseSat) begin
               d.st = SLIP_IDLE;
            end
         end
         SLIP_LOWER: begin
            if (!sl.slipEn || !sl.lowerSat) begin
               d.st = SLIP_IDLE;
            end
         end
         default: begin
            d.st = SLIP_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{st: SLIP_IDLE};
      end else begin
         q <= d;
      end
   end

   assign sl.slipRaise = (q.st == SLIP_RAISE);
   assign sl.slipLower = (q.st == SLIP_LOWER);

   property p_slip_enter;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.st == SLIP_IDLE && sl.slipEn && sl.raiseSat) |=> sl.slipRaise;
   endproperty
   a_slip_enter: assert property (p_slip_enter)
      else $error("slip hold not entered");

   property p_slip_exit;
      @(posedge sys_clk) disable iff (!rst_n)
      (sl.slipRaise && !sl.slipEn) |=> !sl.slipRaise;
   endproperty
   a_slip_exit: assert property (p_slip_exit)
      else $error("slip hold not released");

endmodule

`default_nettype wire

//--- testbench/pfd_divider_model.sv
// Behavioural companion divider driving the divided oscillator pin
// Assumes bench-controlled kicks and the detector's saturation flags
`timescale 1ns/100ps
`default_nettype none

module pfd_divider_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Bench control
   input wire logic kick,
   input wire logic follow,
   // Saturation indications
   input wire logic raiseSaturationFlag,
   input wire logic lowerSaturationFlag,
   // Divided oscillator
   output logic vcoDivIn
);
   logic [2:0] pulseCnt_reg;

   // Pulse is 3 cycles high and at least 4 low, above the 2-cycle minimum
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pulseCnt_reg <= 3'h0;
      end else if (pulseCnt_reg != 3'h0) begin
         pulseCnt_reg <= pulseCnt_reg - 3'h1;
      end else if (kick || (follow && raiseSaturationFlag &&
                            !lowerSaturationFlag)) begin
         pulseCnt_reg <= 3'h6;
      end
   end

   assign vcoDivIn = (pulseCnt_reg > 3'h3);
endmodule

`default_nettype wire

//--- testbench/tb_pfd_top.sv
// Self-checking bench for the detector block top
// Assumes a one-wait-state APB slave and the companion divider model
`include "pfd_map.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_pfd_top
   import pfd_pkg::*;
;
   localparam logic [7:0] A_CFG = {`PFD_IDX_CFG, 2'b00};
   localparam logic [7:0] A_DET = {`PFD_IDX_DETCTL, 2'b00};
   localparam logic [7:0] A_PUMP = {`PFD_IDX_PUMP, 2'b00};
   localparam logic [7:0] A_STAT = {`PFD_IDX_STAT, 2'b00};
   logic sys_clk = 1'b0;
   logic rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic refDivIn, vcoDivIn, kick, follow;
   logic raiseRequest, lowerRequest, offsetToRaise, offsetToLower;
   logic raiseSaturationFlag, lowerSaturationFlag;
   pfd_code_t raiseGain, lowerGain, offsetMag;
   int err_total = 0;
   int n_tests = 0;
   int cycles = 0;

   always #10 sys_clk = ~sys_clk;

   pfd_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .refDivIn(refDivIn), .vcoDivIn(vcoDivIn),
      .raiseRequest(raiseRequest), .lowerRequest(lowerRequest),
      .raiseGain(raiseGain), .lowerGain(lowerGain), .offsetMag(offsetMag),
      .offsetToRaise(offsetToRaise), .offsetToLower(offsetToLower),
      .raiseSaturationFlag(raiseSaturationFlag),
      .lowerSaturationFlag(lowerSaturationFlag));

   pfd_divider_model i_div (.sys_clk(sys_clk), .rst_n(rst_n), .kick(kick),
      .follow(follow), .raiseSaturationFlag(raiseSaturationFlag),
      .lowerSaturationFlag(lowerSaturationFlag), .vcoDivIn(vcoDivIn));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Holds the request until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) check("apb answer", 32'h0, 32'h1);
   endtask

   task automatic do_reset;
      @(posedge sys_clk);
      rst_n <= 1'b0;
      refDivIn <= 1'b0;
      kick <= 1'b0;
      follow <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
   endtask

   task automatic pulse_ref(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         refDivIn <= 1'b1;
         repeat (3) @(posedge sys_clk);
         refDivIn <= 1'b0;
         repeat (2) @(posedge sys_clk);
      end
   endtask

   task automatic kick_for(input int n);
      @(posedge sys_clk);
      kick <= 1'b1;
      repeat (n) @(posedge sys_clk);
      kick <= 1'b0;
   endtask

   function automatic logic out_of(input int s);
      case (s)
         0: return raiseRequest;
         1: return lowerRequest;
         2: return raiseSaturationFlag;
         default: return lowerSaturationFlag;
      endcase
   endfunction

   task automatic wait_val(input int s, input logic v, input int lim,
                           output logic hit);
      hit = 1'b0;
      for (int i = 0; i < lim && !hit; i++) begin
         @(posedge sys_clk);
         hit = (out_of(s) === v);
      end
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic sc_regs;
      logic [31:0] d;
      logic e;
      do_reset();
      apb(1'b0, A_CFG, 32'h0, d, e);
      check("cfg reset", d, `PFD_RST_CFG);
      apb(1'b0, A_DET, 32'h0, d, e);
      check("detctl reset", d, `PFD_RST_DETCTL);
      apb(1'b1, A_PUMP, 32'hffff_ffff, d, e);
      apb(1'b0, A_PUMP, 32'h0, d, e);
      check("pump readback", d, `PFD_MASK_PUMP);
      check("pump fields", {offsetToLower, offsetToRaise, offsetMag,
            lowerGain, raiseGain}, 32'h007f_ffff);
      check("max gain", raiseGain, `PFD_GAIN_STEPS);
      check("both forced", {raiseRequest, lowerRequest}, 2'b11);
      apb(1'b1, A_PUMP, 32'h0028_1515, d, e);
      // Request outputs are registered once more behind the force bits
      repeat (2) @(posedge sys_clk);
      check("raise gain", raiseGain, 7'h15);
      check("lower gain", lowerGain, 7'h2a);
      check("offset", offsetMag, 7'h20);
      check("offset steer", {offsetToRaise, offsetToLower}, 2'b10);
      check("force off", {raiseRequest, lowerRequest}, 2'b00);
      apb(1'b0, 8'h20, 32'h0, d, e);
      check("unmapped err", e, 1'b1);
      check("unmapped data", d, 32'h0);
      apb(1'b1, A_STAT, 32'hffff_ffff, d, e);
      apb(1'b0, A_STAT, 32'h0, d, e);
      check("stat idle", d, 32'h0);
   endtask

   task automatic sc_force(input logic [31:0] v, input logic [1:0] exp);
      logic [31:0] d;
      logic e;
      apb(1'b1, A_PUMP, v, d, e);
      repeat (3) @(posedge sys_clk);
      check("forced requests", {raiseRequest, lowerRequest}, exp);
   endtask

   task automatic sc_detect(input logic sw);
      logic [31:0] d;
      logic e, h;
      do_reset();
      apb(1'b1, A_DET, {27'h0, sw, 4'h0}, d, e);
      pulse_ref(1);
      wait_val(sw ? 1 : 0, 1'b1, 12, h);
      check("leading request", h, 1'b1);
      check("other request", out_of(sw ? 0 : 1), 1'b0);
      kick_for(1);
      wait_val(sw ? 1 : 0, 1'b0, 20, h);
      check("request cleared", h, 1'b1);
      // A lone oscillator edge must now raise the opposite request
      kick_for(8);
      wait_val(sw ? 0 : 1, 1'b1, 20, h);
      check("oscillator side request", h, 1'b1);
   endtask

   task automatic sc_sat(input logic [31:0] cfg, input logic [2:0] dly,
                         input int pulses, input logic expHigh,
                         input logic fol);
      logic [31:0] d;
      logic e, h;
      do_reset();
      apb(1'b1, A_CFG, cfg, d, e);
      apb(1'b1, A_DET, {29'h0, dly}, d, e);
      pulse_ref(pulses);
      wait_val(2, 1'b1, 10, h);
      check("raise saturation", h, expHigh);
      check("lower saturation", lowerSaturationFlag, 1'b0);
      if (expHigh && fol) begin
         follow <= 1'b1;
         wait_val(2, 1'b0, 30, h);
         check("divider catch-up", h, 1'b1);
      end else if (expHigh) begin
         apb(1'b0, A_STAT, 32'h0, d, e);
         check("slip hold status", d[5:0], 6'b010101);
         kick_for(1);
         wait_val(2, 1'b0, 20, h);
         check("hold released", h, 1'b1);
      end
   endtask

   task automatic sc_lowsat;
      logic [31:0] d;
      logic e, h;
      do_reset();
      apb(1'b1, A_CFG, 32'h0000_2010, d, e);
      kick_for(8);
      wait_val(3, 1'b1, 20, h);
      check("lower saturation", h, 1'b1);
      check("lower held", lowerRequest, 1'b1);
      check("raise masked", raiseRequest, 1'b0);
   endtask

   // ------------------------------------------------------------
   // Main sequence and hang guard
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         wrap_up();
      end
   end

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      refDivIn = 1'b0;
      kick = 1'b0;
      follow = 1'b0;
      sc_regs();
      sc_force(32'h0400_0000, 2'b10);
      sc_force(32'h0800_0000, 2'b01);
      sc_force(32'h0000_0000, 2'b00);
      sc_detect(1'b0);
      sc_detect(1'b1);
      sc_sat(32'h0000_0010, 3'h0, 3, 1'b0, 1'b0);
      sc_sat(32'h0000_2000, 3'h0, 3, 1'b0, 1'b0);
      sc_sat(32'h0000_2010, 3'h0, 2, 1'b1, 1'b0);
      sc_sat(32'h0000_2010, 3'h2, 3, 1'b0, 1'b0);
      sc_sat(32'h0000_2010, 3'h2, 4, 1'b1, 1'b1);
      sc_lowsat();
      wrap_up();
   end
endmodule

`default_nettype wire
